/* File: verilog/pll_ctl_params.svh */
// constants for the pll divider and lock control block
`ifndef PLL_CTL_PARAMS_SVH
`define PLL_CTL_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define T_LOGIC_RST_NS 20
`define LOGIC_RST_CYC ((`T_LOGIC_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_LOOP_RST_MS 1
`define LOOP_RST_CYC ((`T_LOOP_RST_MS * 1000000) / `CLK_PERIOD_NS)
`define PHASE_WIN 4'h2
`define NUM_POST 5
`define ADR_CTRL 8'h00
`define ADR_M 8'h04
`define ADR_N 8'h08
`define ADR_V0 8'h0C
`define ADR_QUAL 8'h20
`define ADR_STATUS 8'h24
`define CTRL_MODE_BIT 0
`define CTRL_FBEXT_BIT 1
`define CTRL_FBSRC_LSB 2
`define PRE_MIN 32'h00000001
`define PRE_MAX 32'h00000028
`define POST_MIN 32'h00000002
`define POST_MAX 32'h00000050
`define QUAL_MIN 32'h00000010
`define QUAL_MAX 32'h00000100
`define RST_M 7'h01
`define RST_N 7'h01
`define RST_V 7'h02
`define RST_QUAL 9'h010
`define RST_FB_SRC 3'h0
`endif

/* File: verilog/pll_ctl_pkg.sv */
// types for the pll divider and lock control block
package pll_ctl_pkg;
  typedef enum logic [1:0] {
    LK_UNLOCKED = 2'b00,
    LK_QUALIFY = 2'b01,
    LK_LOCKED = 2'b10
  } lock_state_t;
  typedef enum logic {
    MODE_PHASE = 1'b0,
    MODE_FREQ = 1'b1
  } lock_mode_t;
  typedef struct packed {
    lock_mode_t mode;
    logic fb_ext;
    logic [2:0] fb_src;
    logic [6:0] m;
    logic [6:0] n;
    logic [4:0][6:0] v;
    logic [8:0] qual;
  } cfg_t;
  typedef struct packed {
    logic ref_a;
    logic ref_b;
    logic fbk_a;
    logic fbk_b;
    logic vco;
    logic ref_sel;
    logic fbk_sel;
    logic loop_skip;
    logic logic_rst;
  } pins_t;
endpackage

/* File: verilog/pll_divider_lock_control.sv */
// pll divider chain, input selection and lock detector with wishbone registers
// Notes on behaviour
// - the detector reacts only to rising edges, never to duty cycle
// - lock pin is low while locked and high otherwise
// - lock mode is phase agreement or frequency agreement, chosen by configuration
// - phase mode asserts lock as soon as the condition is seen
// - frequency mode asserts lock after a programmed 16 to 256 detector cycles
// - losing the condition drops lock at once in both modes
// - input prescaler divides the selected reference by 1 to 40
// - feedback prescaler divides the selected feedback by 1 to 40
// - five post dividers divide the vco by even ratios 2 to 80
// - locked output frequency is ref times n times v_fb over m times v_k
// - feedback may come from any post divider, including one driving an output
// - loop skip routes the input prescaler output straight into the post dividers
// - in loop skip each post divider ratio is halved, giving 1 to 40; the code divides a ratio of 2 by 2, so its range is 2 to 40
// - in loop skip the lock detector does not operate
// - select pins pick reference pair a or b and feedback pair a or b
// - short logic reset restarts digital state; a 1 ms pulse resets the loop
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`include "pll_ctl_params.svh"
module pll_divider_lock_control #(
  parameter int unsigned LOOP_RST_CYC = `LOOP_RST_CYC
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic REFERENCE_PAIR_A,
  input wire logic REFERENCE_PAIR_B,
  input wire logic FEEDBACK_PAIR_A,
  input wire logic FEEDBACK_PAIR_B,
  input wire logic VCO_CLK,
  input wire logic REFERENCE_PAIR_SELECT,
  input wire logic FEEDBACK_PAIR_SELECT,
  input wire logic LOOP_SKIP,
  input wire logic LOGIC_RST,
  output logic [4:0] DIV_OUT,
  output logic LOCK_N,
  output logic LOOP_RESET
);
  import pll_ctl_pkg::*;
  localparam int NP = `NUM_POST;
  localparam cfg_t CFG_RST = '{mode: MODE_PHASE, fb_ext: 1'b0, fb_src: `RST_FB_SRC,
    m: `RST_M, n: `RST_N, v: {NP{`RST_V}}, qual: `RST_QUAL};

  if (LOOP_RST_CYC <= `LOGIC_RST_CYC) begin : g_bad_loop_rst
    $error("LOOP_RST_CYC must exceed the logic reset width");
  end

  function automatic logic [7:0] step_div(input logic [6:0] cnt, input logic [6:0] lim);
    if (cnt + 7'h01 >= lim) begin
      return {1'b1, 7'h00};
    end
    return {1'b0, cnt + 7'h01};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic in_range(input logic [31:0] w, input logic [31:0] lo,
                                    input logic [31:0] hi);
    return (w >= lo) && (w <= hi);
  endfunction

  function automatic logic [7:0] v_adr(input int k);
    return `ADR_V0 + 8'(4 * k);
  endfunction

  // pins from outside pass two flops; third stage only feeds edge detection
  pins_t pin_raw, s1_r, s1_nxt, s2_r, s2_nxt, s3_r, s3_nxt, rise;
  assign pin_raw = {REFERENCE_PAIR_A, REFERENCE_PAIR_B, FEEDBACK_PAIR_A, FEEDBACK_PAIR_B,
                    VCO_CLK, REFERENCE_PAIR_SELECT, FEEDBACK_PAIR_SELECT, LOOP_SKIP, LOGIC_RST};
  always_comb begin
    s1_nxt = SRST ? '0 : pin_raw;
    s2_nxt = SRST ? '0 : s1_r;
    s3_nxt = SRST ? '0 : s2_r;
  end
  always_ff @(posedge SYS_CLK) begin
    s1_r <= s1_nxt;
    s2_r <= s2_nxt;
    s3_r <= s3_nxt;
  end
  assign rise = pins_t'(s2_r & ~s3_r);

  logic ref_edge, ext_fb_edge, skip, lrst;
  assign ref_edge = s2_r.ref_sel ? rise.ref_b : rise.ref_a;
  assign ext_fb_edge = s2_r.fbk_sel ? rise.fbk_b : rise.fbk_a;
  assign skip = s2_r.loop_skip;
  assign lrst = s2_r.logic_rst;

  // logic reset width: short pulses below the minimum clear the dividers but do not load the stored settings
  logic [31:0] rlen_r, rlen_nxt;
  logic loop_rst_r, loop_rst_nxt, apply, clr;
  always_comb begin
    rlen_nxt = rlen_r;
    if (SRST || !lrst) begin
      rlen_nxt = 32'h00000000;
    end else if (rlen_r < LOOP_RST_CYC) begin
      rlen_nxt = rlen_r + 32'h00000001;
    end
    loop_rst_nxt = !SRST && lrst && (rlen_nxt >= LOOP_RST_CYC);
  end
  always_ff @(posedge SYS_CLK) begin
    rlen_r <= rlen_nxt;
    loop_rst_r <= loop_rst_nxt;
  end
  assign apply = !lrst && (rlen_r >= `LOGIC_RST_CYC);
  assign clr = SRST || lrst || apply;

  // stored configuration written by software, active copy used by the logic
  cfg_t cfg_r, cfg_nxt, act_r, act_nxt;
  logic ack_r, ack_nxt, wb_hit;
  logic [31:0] dat_r, dat_nxt, rd_word, wr_word;
  lock_state_t st_r, st_nxt;
  logic lock_ok_r, lock_ok_nxt, lock_n_r, lock_n_nxt;
  assign wb_hit = WB_CYC_I && WB_STB_I && !ack_r;

  always_comb begin
    rd_word = 32'h00000000;
    if (WB_ADR_I == `ADR_CTRL) begin
      rd_word[`CTRL_MODE_BIT] = cfg_r.mode;
      rd_word[`CTRL_FBEXT_BIT] = cfg_r.fb_ext;
      rd_word[`CTRL_FBSRC_LSB +: 3] = cfg_r.fb_src;
    end else if (WB_ADR_I == `ADR_M) begin
      rd_word[6:0] = cfg_r.m;
    end else if (WB_ADR_I == `ADR_N) begin
      rd_word[6:0] = cfg_r.n;
    end else if (WB_ADR_I == `ADR_QUAL) begin
      rd_word[8:0] = cfg_r.qual;
    end else if (WB_ADR_I == `ADR_STATUS) begin
      rd_word[6:0] = {cfg_r != act_r, loop_rst_r, skip, st_r, lock_ok_r, !lock_n_r};
    end
    for (int k = 0; k < NP; k++) begin
      if (WB_ADR_I == v_adr(k)) begin
        rd_word[6:0] = cfg_r.v[k];
      end
    end
  end
  assign wr_word = merge(rd_word, WB_DAT_I, WB_SEL_I);

  // out of range writes are dropped, so stored ratios are always legal
  always_comb begin
    cfg_nxt = cfg_r;
    if (SRST) begin
      cfg_nxt = CFG_RST;
    end else if (WB_CYC_I && WB_STB_I && ack_r && WB_WE_I) begin
      // a write lands on the edge at which the master samples ack high
      if (WB_ADR_I == `ADR_CTRL) begin
        cfg_nxt.mode = lock_mode_t'(wr_word[`CTRL_MODE_BIT]);
        cfg_nxt.fb_ext = wr_word[`CTRL_FBEXT_BIT];
        if (wr_word[`CTRL_FBSRC_LSB +: 3] < 3'(NP)) begin
          cfg_nxt.fb_src = wr_word[`CTRL_FBSRC_LSB +: 3];
        end
      end else if (WB_ADR_I == `ADR_M && in_range(wr_word, `PRE_MIN, `PRE_MAX)) begin
        cfg_nxt.m = wr_word[6:0];
      end else if (WB_ADR_I == `ADR_N && in_range(wr_word, `PRE_MIN, `PRE_MAX)) begin
        cfg_nxt.n = wr_word[6:0];
      end else if (WB_ADR_I == `ADR_QUAL && in_range(wr_word, `QUAL_MIN, `QUAL_MAX)) begin
        cfg_nxt.qual = wr_word[8:0];
      end
      for (int k = 0; k < NP; k++) begin
        if (WB_ADR_I == v_adr(k) && in_range(wr_word, `POST_MIN, `POST_MAX) && !wr_word[0]) begin
          cfg_nxt.v[k] = wr_word[6:0];
        end
      end
    end
    act_nxt = SRST ? CFG_RST : (apply ? cfg_r : act_r);
    ack_nxt = !SRST && wb_hit;
    dat_nxt = (wb_hit && !WB_WE_I) ? rd_word : dat_r;
    if (SRST) begin
      dat_nxt = 32'h00000000;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    cfg_r <= cfg_nxt;
    act_r <= act_nxt;
    ack_r <= ack_nxt;
    dat_r <= dat_nxt;
  end

  // prescalers and post dividers, counting edges of the sampled clocks
  logic [6:0] m_cnt_r, m_cnt_nxt, n_cnt_r, n_cnt_nxt;
  logic [NP-1:0][6:0] pc_r, pc_nxt;
  logic [NP-1:0] div_r, div_nxt, post_rise;
  logic m_str, n_str, fb_edge;
  assign fb_edge = act_r.fb_ext ? ext_fb_edge : post_rise[act_r.fb_src];
  always_comb begin
    logic [7:0] st;
    logic [6:0] half;
    logic [7:0] acc;
    st = 8'h00;
    half = 7'h00;
    acc = 8'h00;
    m_cnt_nxt = m_cnt_r;
    n_cnt_nxt = n_cnt_r;
    m_str = 1'b0;
    n_str = 1'b0;
    if (ref_edge) begin
      st = step_div(m_cnt_r, act_r.m);
      m_str = st[7];
      m_cnt_nxt = st[6:0];
    end
    if (fb_edge && !skip) begin
      st = step_div(n_cnt_r, act_r.n);
      n_str = st[7];
      n_cnt_nxt = st[6:0];
    end
    pc_nxt = pc_r;
    div_nxt = div_r;
    post_rise = '0;
    for (int k = 0; k < NP; k++) begin
      half = act_r.v[k] >> 1;
      if (skip && m_str) begin
        // two half units per prescaler strobe halves the ratio; a ratio of 2 toggles each strobe and so divides by 2
        acc = {1'b0, pc_r[k]} + 8'h02;
        if (acc >= {1'b0, half}) begin
          acc = acc - {1'b0, half};
          div_nxt[k] = !div_r[k];
          if (acc >= {1'b0, half}) begin
            acc = 8'h00;
          end
        end
        pc_nxt[k] = acc[6:0];
      end else if (!skip && rise.vco) begin
        st = step_div(pc_r[k], half);
        pc_nxt[k] = st[6:0];
        div_nxt[k] = div_r[k] ^ st[7];
      end
      post_rise[k] = div_nxt[k] && !div_r[k];
    end
    if (clr) begin
      m_cnt_nxt = 7'h00;
      n_cnt_nxt = 7'h00;
      pc_nxt = '0;
      div_nxt = '0;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    m_cnt_r <= m_cnt_nxt;
    n_cnt_r <= n_cnt_nxt;
    pc_r <= pc_nxt;
    div_r <= div_nxt;
  end

  // detector: phase needs a feedback strobe close to each reference strobe,
  // frequency needs exactly one feedback strobe per reference period
  logic [3:0] nage_r, nage_nxt;
  logic [1:0] ncnt_r, ncnt_nxt;
  logic [8:0] qual_r, qual_nxt;
  logic phase_ok, freq_ok;
  always_comb begin
    nage_nxt = n_str ? 4'h0 : ((nage_r == 4'hF) ? nage_r : nage_r + 4'h1);
    ncnt_nxt = ncnt_r;
    if (m_str) begin
      ncnt_nxt = 2'h0;
    end else if (n_str && ncnt_r != 2'h3) begin
      ncnt_nxt = ncnt_r + 2'h1;
    end
    phase_ok = n_str || (nage_r < `PHASE_WIN);
    freq_ok = (ncnt_r + 2'(n_str)) == 2'h1;
    lock_ok_nxt = lock_ok_r;
    if (clr || skip) begin
      lock_ok_nxt = 1'b0;
    end else if (m_str) begin
      lock_ok_nxt = (act_r.mode == MODE_FREQ) ? freq_ok : phase_ok;
    end
    st_nxt = st_r;
    qual_nxt = qual_r;
    if (clr || skip || !lock_ok_r) begin
      st_nxt = LK_UNLOCKED;
      qual_nxt = 9'h000;
    end else begin
      unique case (st_r)
        LK_UNLOCKED: begin
          if (act_r.mode == MODE_PHASE) begin
            st_nxt = LK_LOCKED;
          end else begin
            st_nxt = LK_QUALIFY;
            qual_nxt = 9'h000;
          end
        end
        LK_QUALIFY: begin
          if (m_str) begin
            qual_nxt = qual_r + 9'h001;
            if (qual_nxt >= act_r.qual) begin
              st_nxt = LK_LOCKED;
            end
          end
        end
        LK_LOCKED: begin
        end
        default: begin
          st_nxt = LK_UNLOCKED;
        end
      endcase
    end
    lock_n_nxt = (st_nxt != LK_LOCKED);
    if (clr) begin
      nage_nxt = 4'hF;
      ncnt_nxt = 2'h0;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    nage_r <= nage_nxt;
    ncnt_r <= ncnt_nxt;
    lock_ok_r <= lock_ok_nxt;
    st_r <= st_nxt;
    qual_r <= qual_nxt;
    lock_n_r <= lock_n_nxt;
  end

  assign WB_DAT_O = dat_r;
  assign WB_ACK_O = ack_r;
  assign DIV_OUT = div_r;
  assign LOCK_N = lock_n_r;
  assign LOOP_RESET = loop_rst_r;

  default clocking ck @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);
  sequence lost_s;
    !lock_ok_r;
  endsequence
  sequence m_wrap_s;
    m_str;
  endsequence
  lock_drop_a: assert property (lost_s |=> LOCK_N) else $error("lock held after loss");
  skip_nolock_a: assert property (skip |=> LOCK_N && st_r == LK_UNLOCKED)
    else $error("lock active in loop skip");
  phase_fast_a: assert property ((act_r.mode == MODE_PHASE && lock_ok_r && !clr && !skip)
    |=> !LOCK_N) else $error("phase mode lock delayed");
  freq_qual_a: assert property ((act_r.mode == MODE_FREQ && $fell(LOCK_N))
    |-> qual_r >= act_r.qual) else $error("frequency lock too early");
  qual_clear_a: assert property (lost_s |=> qual_r == 9'h000) else $error("count kept");
  m_ratio_a: assert property (m_wrap_s |-> m_cnt_r + 7'h01 == act_r.m ##1 m_cnt_r == 7'h00)
    else $error("input prescaler ratio wrong");
  n_ratio_a: assert property (n_str |-> n_cnt_r + 7'h01 == act_r.n ##1 n_cnt_r == 7'h00)
    else $error("feedback prescaler ratio wrong");
  cfg_apply_a: assert property ($changed(act_r) |-> $past(apply))
    else $error("configuration changed without reset");
  post_edge_a: assert property (($changed(div_r) && !$past(skip) && !$past(clr))
    |-> $past(rise.vco)) else $error("post divider moved without vco edge");
  loop_rst_a: assert property ($rose(LOOP_RESET) |-> $past(lrst) && rlen_r >= LOOP_RST_CYC)
    else $error("loop reset too early");
endmodule // pll_divider_lock_control

/* File: dv/clk_source_model.sv */
// board clock source for the pll control bench: reference, feedback and vco lines
`timescale 1ns/1ns
module clk_source_model (
  input wire logic clk,
  input wire logic [4:0][7:0] half,
  input wire logic [7:0] fbk_ofs,
  output logic [4:0] lines
);
  int unsigned t = 0;
  initial lines = '0;
  // one shared time base keeps reference and feedback edges in a known phase
  always @(posedge clk) begin
    t <= t + 1;
    for (int k = 0; k < 5; k++) begin
      // a stopped clock rests low, never at its last level by chance
      if (half[k] == 8'h00) begin
        lines[k] <= 1'b0;
      end else begin
        lines[k] <= (((t + ((k == 2 || k == 3) ? fbk_ofs : 8'h00)) / half[k]) % 2) == 1;
      end
    end
  end
endmodule // clk_source_model

/* File: dv/pll_divider_lock_control_test.sv */
// self-checking bench for the pll divider and lock control block
`timescale 1ns/1ns
`include "pll_ctl_params.svh"
module pll_divider_lock_control_test;
  logic clk = 1'b0, srst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, ack_o;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic [3:0] sel = 4'hF;
  logic ref_sel = 1'b0, fbk_sel = 1'b0, skip = 1'b0, lrst = 1'b0, lock_n, loop_rst;
  logic [4:0] div_out, lines;
  // reference periods of 12 and 10 cycles keep prescaler outputs above 8 MHz
  logic [4:0][7:0] half = '0;
  logic [7:0] ofs = 8'h00;
  int n;
  int fail_count = 0, compares = 0;

  pll_divider_lock_control #(.LOOP_RST_CYC(20)) pll_divider_lock_control_i (
    .SYS_CLK(clk), .SRST(srst), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel),
    .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dat_o), .WB_ACK_O(ack_o),
    .REFERENCE_PAIR_A(lines[0]), .REFERENCE_PAIR_B(lines[1]), .FEEDBACK_PAIR_A(lines[2]),
    .FEEDBACK_PAIR_B(lines[3]), .VCO_CLK(lines[4]), .REFERENCE_PAIR_SELECT(ref_sel),
    .FEEDBACK_PAIR_SELECT(fbk_sel), .LOOP_SKIP(skip), .LOGIC_RST(lrst),
    .DIV_OUT(div_out), .LOCK_N(lock_n), .LOOP_RESET(loop_rst));
  clk_source_model clk_source_model_i (.clk(clk), .half(half), .fbk_ofs(ofs), .lines(lines));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask

  // classic single cycle: request held until ack is sampled, then released
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge clk);
    {adr, we, wdat, cyc, stb} <= {a, w, d, 2'b11};
    do begin
      @(posedge clk);
      c++;
    end while (ack_o !== 1'b1 && c < 20);
    rdat = dat_o;
    {we, cyc, stb} <= 3'b000;
    check("wb_ack", c < 20, 1'b1);
  endtask

  task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    check(s, rdat, e);
  endtask

  // stored settings only reach the dividers through a logic reset pulse
  task automatic apply(input int len);
    @(posedge clk);
    lrst <= 1'b1;
    tick(len);
    lrst <= 1'b0;
    tick(6);
  endtask

  task automatic wait_lock(input logic lvl, input int lim);
    n = 0;
    while (lock_n !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic rise(input int k);
    n = 0;
    while (div_out[k] !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    while (div_out[k] !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic period(input int k, input int e);
    rise(k);
    rise(k);
    check("div_period", n, e);
  endtask

  task automatic t_reset();
    check("lock_n_rst", lock_n, 1'b1);
    check("div_rst", div_out, 5'h00);
    rdchk("ctrl_rst", `ADR_CTRL, 32'h0);
    rdchk("m_rst", `ADR_M, 32'h1);
    rdchk("n_rst", `ADR_N, 32'h1);
    rdchk("qual_rst", `ADR_QUAL, 32'h10);
    for (int k = 0; k < 5; k++) begin
      rdchk("v_rst", 8'(`ADR_V0 + 4 * k), 32'h2);
    end
  endtask

  task automatic t_refuse();
    logic [7:0] a [9] = '{`ADR_M, `ADR_M, `ADR_N, `ADR_V0, `ADR_V0, `ADR_QUAL, `ADR_QUAL,
                          `ADR_CTRL, 8'h30};
    logic [31:0] d [9] = '{32'h29, 32'h28, 32'h0, 32'h3, 32'h50, 32'hF, 32'h100, 32'h14, 32'h5};
    logic [31:0] e [9] = '{32'h1, 32'h28, 32'h1, 32'h2, 32'h50, 32'h10, 32'h100, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) begin
      wb(a[i], 1'b1, d[i]);
      rdchk("range", a[i], e[i]);
    end
    sel <= 4'h0;
    wb(`ADR_M, 1'b1, 32'h7);
    sel <= 4'hF;
    rdchk("no_bytes", `ADR_M, 32'h28);
  endtask

  task automatic t_pin_reset();
    wb(`ADR_M, 1'b1, 32'h1);
    wb(`ADR_V0, 1'b1, 32'h2);
    wb(`ADR_STATUS, 1'b0, 32'h0);
    check("pending", rdat[6], 1'b1);
    apply(4);
    check("loop_rst_short", loop_rst, 1'b0);
    wb(`ADR_STATUS, 1'b0, 32'h0);
    check("applied", rdat[6], 1'b0);
    @(posedge clk);
    lrst <= 1'b1;
    tick(28);
    check("loop_rst_long", loop_rst, 1'b1);
    check("lock_held", lock_n, 1'b1);
    lrst <= 1'b0;
    tick(6);
  endtask

  task automatic t_dividers();
    logic [31:0] v [5] = '{32'h2, 32'h4, 32'h6, 32'h8, 32'h50};
    half[4] <= 8'h03;
    for (int k = 0; k < 5; k++) begin
      wb(8'(`ADR_V0 + 4 * k), 1'b1, v[k]);
    end
    apply(4);
    for (int k = 0; k < 5; k++) begin
      period(k, v[k] * 6);
    end
  endtask

  task automatic t_internal();
    half[0] <= 8'h06;
    wb(`ADR_CTRL, 1'b1, 32'h5);
    wb(`ADR_V0, 1'b1, 32'h4);
    wb(`ADR_V0 + 8'h04, 1'b1, 32'h2);
    wb(`ADR_QUAL, 1'b1, 32'h10);
    apply(4);
    wait_lock(1'b0, 400);
    check("int_lock", n < 400, 1'b1);
    period(0, 24);
    period(1, 12);
    wb(`ADR_CTRL, 1'b1, 32'h1);
    apply(4);
    tick(400);
    check("int_wrong_fb", lock_n, 1'b1);
  endtask

  task automatic t_phase();
    half[2] <= 8'h09;
    half[3] <= 8'h06;
    wb(`ADR_CTRL, 1'b1, 32'h2);
    apply(4);
    tick(200);
    check("fbk_pair_a", lock_n, 1'b1);
    fbk_sel <= 1'b1;
    // a pair switch without prescaler bypass is followed by a reset
    apply(4);
    wait_lock(1'b0, 40);
    check("phase_lock", n < 40, 1'b1);
    ofs <= 8'h06;
    wait_lock(1'b1, 30);
    check("phase_loss", n < 30, 1'b1);
    tick(200);
    check("phase_off", lock_n, 1'b1);
  endtask

  task automatic t_freq();
    wb(`ADR_CTRL, 1'b1, 32'h3);
    apply(4);
    wait_lock(1'b0, 400);
    check("freq_qual", n >= 192 && n <= 270, 1'b1);
    half[3] <= 8'h00;
    wait_lock(1'b1, 30);
    check("freq_loss", n < 30, 1'b1);
    tick(40);
    half[3] <= 8'h06;
    wait_lock(1'b0, 400);
    check("freq_requal", n >= 192 && n <= 270, 1'b1);
  endtask

  task automatic t_skip();
    skip <= 1'b1;
    wb(`ADR_V0, 1'b1, 32'h8);
    apply(4);
    period(0, 48);
    tick(300);
    check("skip_no_lock", lock_n, 1'b1);
    half[1] <= 8'h05;
    ref_sel <= 1'b1;
    apply(4);
    period(0, 40);
    skip <= 1'b0;
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    tick(5);
    srst <= 1'b0;
    t_reset();
    t_refuse();
    t_pin_reset();
    t_dividers();
    t_internal();
    t_phase();
    t_freq();
    t_skip();
    tally_and_finish();
  end

  // the whole run needs well under 10000 cycles
  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end
endmodule // pll_divider_lock_control_test
